// ==== verilog/sar_map.vh ====
`ifndef SAR_MAP_VH
`define SAR_MAP_VH

// Result word and sample widths
`define SAR_RES_W        10
`define SAR_IN_W         12
`define SAR_TAG_W        2

// Output code limits
`define SAR_CODE_ZERO    10'h000
`define SAR_CODE_FULL    10'h3FF

// Rising-edge positions of the command bits after the start bit
`define SAR_CNT_W        4
`define SAR_CNT_CLR      4'h0
`define SAR_CNT_MODE     4'h0
`define SAR_CNT_SIGN     4'h1
`define SAR_CNT_ORDER    4'h2

// Falling-edge positions of the last bit of each output phase
`define SAR_CNT_MSB_LAST 4'h9
`define SAR_CNT_LSB_LAST 4'h8
`define SAR_CNT_ONE      4'h1

// Result buffer size
`define SAR_FIFO_DEPTH   32
`define SAR_FIFO_AW      5

`endif

// ==== verilog/sar_fifo.v ====
// Result buffer with registered show-ahead output
module sar_fifo #(
   parameter W     = 12,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire         mclk_i,
   input  wire         rst_i,
   input  wire [W-1:0] in_data_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   output reg  [W-1:0] out_data_o,
   output reg          out_valid_o,
   input  wire         out_ready_i
);

   reg [W-1:0]  mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0]   count;

   wire          push = in_valid_i & in_ready_o;
   wire          pop  = out_valid_o & out_ready_i;
   wire [AW-1:0] next_rd_ptr = rd_ptr + {{(AW-1){1'b0}}, pop};
   wire [AW:0]   next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   wire [31:0]   depth_w     = DEPTH;

   // Full when every entry holds a word
   assign in_ready_o = ({{(31-AW){1'b0}}, count} != depth_w);

   // Storage write
   always @(posedge mclk_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers, fill level and the registered head word
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_ptr      <= {AW{1'b0}};
         rd_ptr      <= {AW{1'b0}};
         count       <= {(AW+1){1'b0}};
         out_valid_o <= 1'b0;
         out_data_o  <= {W{1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         rd_ptr      <= next_rd_ptr;
         count       <= next_count;
         out_valid_o <= (next_count != {(AW+1){1'b0}});
         // Bypass a word written into the slot that becomes the head
         if (push && (wr_ptr == next_rd_ptr))
            out_data_o <= in_data_i;
         else
            out_data_o <= mem[next_rd_ptr];
      end
   end

endmodule // sar_fifo

// ==== verilog/sar_serial_core.v ====
`include "sar_map.vh"

// Functional notes
// - A transaction starts only after select_n_shutdown falls low.
// - Select high aborts any conversion and enters standby.
// - While select is low, serial output changes only on serial clock falling edges; select high forces it low.
// - Sample switch closes at second rise after start, for 1.5 clocks.
// - Held sample resolves to a 10-bit result, one bit per clock.
// - Host serial clock alone starts conversion and shifts results.
// - Channel configuration from the command applies to the conversion in the same frame.
// - Two single-ended inputs or one pseudo-differential pair.
// - Pseudo-differential with positive at or below negative gives 000h.
// - Pseudo-differential difference at full scale saturates at 3FFh.
// - Code is 1024 times input over supply; inputs arrive in LSB units.
// - Link is serial clock, serial in, serial out, framed by select.
// - First rise with select low and serial in high is start bit; a full result buffer refuses it.
// - Command bits after start: input_mode_bit, polarity bit, first_order_bit.
// - Null low bit on first_order_bit fall, then 10 bits MSB first.
// - Order high gives zeros after MSB word; low repeats LSB first, then zeros.
module sar_serial_core #(
   parameter IN_W       = `SAR_IN_W,
   parameter FIFO_DEPTH = `SAR_FIFO_DEPTH,
   parameter FIFO_AW    = `SAR_FIFO_AW
) (
   input  wire                             mclk_i,
   input  wire                             rst_i,
   input  wire                             select_n_shutdown_i,
   input  wire                             sclk_i,
   input  wire                             serial_in_i,
   output reg                              serial_out_o,
   output reg                              serial_out_oe_o,
   input  wire [IN_W-1:0]                  analog_input_a_i,
   input  wire [IN_W-1:0]                  analog_input_b_i,
   output reg                              sample_switch_o,
   output reg                              standby_o,
   output wire [`SAR_TAG_W+`SAR_RES_W-1:0] result_data_o,
   output wire                             result_valid_o,
   input  wire                             result_ready_i
);

   localparam RW = `SAR_RES_W;
   localparam DW = `SAR_TAG_W + `SAR_RES_W;

   // One-hot transaction states
   localparam [6:0] ST_STANDBY = 7'h01;
   localparam [6:0] ST_HUNT    = 7'h02;
   localparam [6:0] ST_CMD     = 7'h04;
   localparam [6:0] ST_SAMPLE  = 7'h08;
   localparam [6:0] ST_MSB     = 7'h10;
   localparam [6:0] ST_LSB     = 7'h20;
   localparam [6:0] ST_ZERO    = 7'h40;

   reg [6:0]            state;
   reg [`SAR_CNT_W-1:0] bit_cnt;
   reg                  sclk_q;
   reg                  select_q;
   reg                  input_mode_bit;
   reg                  channel_polarity_bit;
   reg                  first_order_bit;
   reg [RW-1:0]         result;
   reg [RW-1:0]         shift_word;
   reg [DW-1:0]         push_data;
   reg                  push_valid;
   wire                 push_ready;
   reg [RW-1:0]         next_code;
   reg                  next_serial_bit;

   // Host serial clock and select edges seen on the system clock
   wire sclk_rise = sclk_i & ~sclk_q;
   wire sclk_fall = ~sclk_i & sclk_q;
   wire select_fall = select_q & ~select_n_shutdown_i;

   // A start bit has been taken and the frame is under way
   wire frame_open = ~state[0] & ~state[1];

   // Ideal converter: inputs already scaled to 1024 * Vin / Vdd
   function [RW-1:0] sar_code;
      input            mode;
      input            polarity;
      input [IN_W-1:0] in_a;
      input [IN_W-1:0] in_b;
      reg   [IN_W-1:0] pos;
      reg   [IN_W-1:0] neg;
      reg   [IN_W-1:0] diff;
      reg   [IN_W-1:0] full;
      begin
         pos  = polarity ? in_b : in_a;
         neg  = polarity ? in_a : in_b;
         full = {{(IN_W-RW){1'b0}}, `SAR_CODE_FULL};
         diff = pos - neg;
         sar_code = `SAR_CODE_ZERO;
         if (mode)
         begin
            // Single-ended against ground, channel chosen by polarity bit
            if (pos >= full)
               sar_code = `SAR_CODE_FULL;
            else
               sar_code = pos[RW-1:0];
         end
         else if (pos <= neg)
         begin
            sar_code = `SAR_CODE_ZERO;
         end
         else if (diff >= full)
         begin
            sar_code = `SAR_CODE_FULL;
         end
         else
         begin
            sar_code = diff[RW-1:0];
         end
      end
   endfunction

   // Code of the held sample under the captured command
   always @*
   begin
      next_code = sar_code(input_mode_bit, channel_polarity_bit,
                           analog_input_a_i, analog_input_b_i);
   end

   // Bit for the line at the next serial clock fall
   always @*
   begin
      next_serial_bit = 1'b0;
      case (state)
         ST_MSB:
         begin
            next_serial_bit = shift_word[RW-1];
         end
         ST_LSB:
         begin
            next_serial_bit = result[bit_cnt + `SAR_CNT_ONE];
         end
         default:
         begin
            // Null bit after the order bit, then trailing zeros
            next_serial_bit = 1'b0;
         end
      endcase
   end

   // Serial output pin and its driver enable
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         serial_out_o    <= 1'b0;
         serial_out_oe_o <= 1'b0;
      end
      else if (select_n_shutdown_i)
      begin
         // Released while select is high
         serial_out_o    <= 1'b0;
         serial_out_oe_o <= 1'b0;
      end
      else if (sclk_fall && frame_open)
      begin
         serial_out_o    <= next_serial_bit;
         serial_out_oe_o <= 1'b1;
      end
   end

   // Sample switch: closes on the polarity-bit rise, opens on the order-bit fall
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sample_switch_o <= 1'b0;
      end
      else if (select_n_shutdown_i)
      begin
         sample_switch_o <= 1'b0;
      end
      else if (sclk_rise && (state == ST_CMD) && (bit_cnt == `SAR_CNT_SIGN))
      begin
         sample_switch_o <= 1'b1;
      end
      else if (sclk_fall && (state == ST_SAMPLE))
      begin
         sample_switch_o <= 1'b0;
      end
   end

   // Edge history of the serial clock and select
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sclk_q    <= 1'b0;
         select_q  <= 1'b0;
         standby_o <= 1'b1;
      end
      else
      begin
         sclk_q    <= sclk_i;
         select_q  <= select_n_shutdown_i;
         standby_o <= select_n_shutdown_i;
      end
   end

   // Transaction sequencer
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state                <= ST_STANDBY;
         bit_cnt              <= `SAR_CNT_CLR;
         input_mode_bit       <= 1'b0;
         channel_polarity_bit <= 1'b0;
         first_order_bit      <= 1'b0;
         result               <= `SAR_CODE_ZERO;
         shift_word           <= `SAR_CODE_ZERO;
         push_valid           <= 1'b0;
         push_data            <= {DW{1'b0}};
      end
      else if (select_n_shutdown_i)
      begin
         // Select high: abort and forget the command
         state                <= ST_STANDBY;
         bit_cnt              <= `SAR_CNT_CLR;
         input_mode_bit       <= 1'b0;
         channel_polarity_bit <= 1'b0;
         first_order_bit      <= 1'b0;
         push_valid           <= 1'b0;
      end
      else
      begin
         push_valid <= 1'b0;
         case (state)
            ST_STANDBY:
            begin
               // Only a fresh falling select opens a transaction
               if (select_fall)
               begin
                  state <= ST_HUNT;
               end
            end
            ST_HUNT:
            begin
               // Leading zeros are skipped; a full buffer refuses the start
               if (sclk_rise && serial_in_i && push_ready)
               begin
                  state   <= ST_CMD;
                  bit_cnt <= `SAR_CNT_CLR;
               end
            end
            ST_CMD:
            begin
               if (sclk_rise)
               begin
                  bit_cnt <= bit_cnt + `SAR_CNT_ONE;
                  if (bit_cnt == `SAR_CNT_MODE)
                  begin
                     input_mode_bit <= serial_in_i;
                  end
                  else if (bit_cnt == `SAR_CNT_SIGN)
                  begin
                     channel_polarity_bit <= serial_in_i;
                  end
                  else
                  begin
                     first_order_bit <= serial_in_i;
                     state           <= ST_SAMPLE;
                  end
               end
            end
            ST_SAMPLE:
            begin
               // Sample is held on the order-bit fall and its code latched
               if (sclk_fall)
               begin
                  result     <= next_code;
                  shift_word <= next_code;
                  push_data  <= {input_mode_bit, channel_polarity_bit, next_code};
                  push_valid <= 1'b1;
                  bit_cnt    <= `SAR_CNT_CLR;
                  state      <= ST_MSB;
               end
            end
            ST_MSB:
            begin
               // Ten result bits, most significant first
               if (sclk_fall)
               begin
                  shift_word <= {shift_word[RW-2:0], 1'b0};
                  if (bit_cnt == `SAR_CNT_MSB_LAST)
                  begin
                     bit_cnt <= `SAR_CNT_CLR;
                     state   <= first_order_bit ? ST_ZERO : ST_LSB;
                  end
                  else
                  begin
                     bit_cnt <= bit_cnt + `SAR_CNT_ONE;
                  end
               end
            end
            ST_LSB:
            begin
               // Bit 0 was shared with the MSB word; continue from bit 1
               if (sclk_fall)
               begin
                  if (bit_cnt == `SAR_CNT_LSB_LAST)
                  begin
                     state <= ST_ZERO;
                  end
                  else
                  begin
                     bit_cnt <= bit_cnt + `SAR_CNT_ONE;
                  end
               end
            end
            ST_ZERO:
            begin
               // Zeros for as long as clocks keep coming, until select rises
               state <= ST_ZERO;
            end
            default:
            begin
               state <= ST_STANDBY;
            end
         endcase
      end
   end

   // Completed results wait here for the user side
   sar_fifo #(
      .W     (DW),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_result_fifo (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .in_data_i   (push_data),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .out_data_o  (result_data_o),
      .out_valid_o (result_valid_o),
      .out_ready_i (result_ready_i)
   );

endmodule // sar_serial_core

// ==== testbench/sar_serial_core_asserts.sv ====
`include "sar_map.vh"

// Port-level checks of the serial converter core
module sar_serial_core_chk (
   input logic                             mclk_i,
   input logic                             rst_i,
   input logic                             select_n_shutdown_i,
   input logic                             sclk_i,
   input logic                             serial_out_o,
   input logic                             serial_out_oe_o,
   input logic                             sample_switch_o,
   input logic                             standby_o,
   input logic [`SAR_TAG_W+`SAR_RES_W-1:0] result_data_o,
   input logic                             result_valid_o,
   input logic                             result_ready_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Short aliases for the select and serial clock pins
   wire sel = select_n_shutdown_i;
   wire sc  = sclk_i;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   // Serial pin, sample switch, standby output and result buffer relations
   chk_oe_idle: assert property (
      sel && $past(sel) && $past(sel, 2) |-> !serial_out_oe_o) else $error("oe in standby");
   chk_oe_start: assert property (
      $rose(serial_out_oe_o) |-> !sel && !$past(sc) && $past(sc, 2)) else $error("oe rise");
   chk_out_fall: assert property (
      $changed(serial_out_o) && serial_out_oe_o && $past(serial_out_oe_o)
      |-> !$past(sc) && $past(sc, 2)) else $error("dout off fall");
   chk_sw_rise: assert property (
      $rose(sample_switch_o) |-> $past(sc) && !$past(sc, 2)) else $error("switch close");
   chk_sw_fall: assert property (
      $fell(sample_switch_o) && !sel |-> !$past(sc) && $past(sc, 2)) else $error("switch open");
   chk_null_bit: assert property (
      $fell(sample_switch_o) && !sel |-> !serial_out_o && serial_out_oe_o) else $error("null bit");
   chk_sw_abort: assert property (
      sel && $past(sel) && $past(sel, 2) |-> !sample_switch_o) else $error("switch in standby");
   chk_standby_lag: assert property (
      standby_o == $past(sel)) else $error("standby level");
   chk_push_valid: assert property (
      $fell(sample_switch_o) && !sel && !result_valid_o |=> result_valid_o) else $error("no push");
   chk_head_hold: assert property (
      result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_data_o))
      else $error("head lost");
endmodule // sar_serial_core_chk

bind sar_serial_core sar_serial_core_chk u_chk (.mclk_i, .rst_i, .select_n_shutdown_i,
   .sclk_i, .serial_out_o, .serial_out_oe_o, .sample_switch_o, .standby_o, .result_data_o,
   .result_valid_o, .result_ready_i);

// ==== testbench/sar_host_model.sv ====
// Serial master on the far side, clock idles low
module sar_host_model (
   input  logic mclk_i,
   output logic sel_n_o,
   output logic sclk_o,
   output logic sdi_o,
   input  logic dout_i,
   input  logic oe_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last;
   logic line;

   // Released output line shows the inverse of the last driven bit
   assign line = oe_i ? dout_i : ~last;
   always @(posedge mclk_i)
      if (oe_i)
         last <= dout_i;

   initial
   begin
      sel_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      last = 1'b0;
   end

   // One framed transfer: leading zeros, start, mode, polarity, order, then zeros
   task automatic xfer(input int lead, input logic [2:0] cfg, input int n,
                       output logic [63:0] rx);
      int i;
      rx = '0;
      @(negedge mclk_i);
      sel_n_o = 1'b0;
      repeat (4) @(negedge mclk_i);
      for (i = 0; i < n; i++)
      begin
         sdi_o = (i < lead) ? 1'b0 : (i == lead) ? 1'b1 :
                 (i <= lead + 3) ? cfg[lead+3-i] : 1'b0;
         repeat (4) @(negedge mclk_i);
         sclk_o = 1'b1;
         rx[i] = line;
         repeat (4) @(negedge mclk_i);
         sclk_o = 1'b0;
      end
      repeat (4) @(negedge mclk_i);
      sel_n_o = 1'b1;
      repeat (8) @(negedge mclk_i);
   endtask
endmodule // sar_host_model

// ==== testbench/dual_channel_sar_adc_serial_port_tb.sv ====
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
   $display("Error %s exp %h got %h", n, e, s); end end

module dual_channel_sar_adc_serial_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i = 1'b0;
   logic        rst_i, sel_n, sclk, sdi, sout, soe, sw, stby, valid, ready;
   logic [11:0] ain_a, ain_b, data;
   logic [63:0] rx;
   int          err_total, cmp_count, cyc;

   always #2 mclk_i = ~mclk_i;

   sar_serial_core DUT (.mclk_i(mclk_i), .rst_i(rst_i), .select_n_shutdown_i(sel_n),
      .sclk_i(sclk), .serial_in_i(sdi), .serial_out_o(sout), .serial_out_oe_o(soe),
      .analog_input_a_i(ain_a), .analog_input_b_i(ain_b), .sample_switch_o(sw),
      .standby_o(stby), .result_data_o(data), .result_valid_o(valid), .result_ready_i(ready));
   sar_host_model host (.mclk_i(mclk_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi),
      .dout_i(sout), .oe_i(soe));

   task end_sim();
      if (err_total == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Cut a hang short
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         end_sim();
      end
   end

   // Ideal code from the selected inputs, clipped at full scale
   function automatic logic [9:0] exp_code(input logic m, p, input logic [11:0] a, b);
      logic [11:0] d;
      if (m)
         d = p ? b : a;
      else
         d = ((p ? b : a) <= (p ? a : b)) ? 12'h000 : (p ? b - a : a - b);
      return (d >= 12'h3FF) ? 10'h3FF : d[9:0];
   endfunction

   // Take the buffer head
   task pop();
      @(negedge mclk_i);
      ready = 1'b1;
      @(negedge mclk_i);
      ready = 1'b0;
      @(negedge mclk_i);
   endtask

   // One conversion, judged on the serial line and at the result buffer
   task automatic run_conv(input int lead, input logic m, p, o, input logic [11:0] a, b,
                           input int n);
      logic [9:0] c;
      int         k;
      @(negedge mclk_i);
      ain_a = a;
      ain_b = b;
      c = exp_code(m, p, a, b);
      host.xfer(lead, {m, p, o}, n, rx);
      `CHK("null", 1'b0, rx[lead+4])
      for (k = 0; k < 10; k++) `CHK("msb", c[9-k], rx[lead+5+k])
      if (!o) for (k = 0; k < 9; k++) `CHK("lsb", c[k+1], rx[lead+15+k])
      for (k = lead + (o ? 15 : 24); k < n; k++) `CHK("zero", 1'b0, rx[k])
      `CHK("idle", 2'b10, {stby, soe})
      `CHK("word", {1'b1, m, p, c}, {valid, data})
      pop();
   endtask

   task t_single();
      run_conv(0, 1'b1, 1'b0, 1'b1, 12'h155, 12'h2AA, 20);
      run_conv(0, 1'b1, 1'b1, 1'b1, 12'h155, 12'h2AA, 20);
      run_conv(1, 1'b1, 1'b1, 1'b0, 12'h000, 12'h7FF, 28);
   endtask

   task t_diff();
      run_conv(2, 1'b0, 1'b0, 1'b0, 12'h300, 12'h010, 30);
      run_conv(0, 1'b0, 1'b1, 1'b1, 12'h300, 12'h010, 16);
      run_conv(0, 1'b0, 1'b0, 1'b1, 12'h080, 12'h080, 16);
      run_conv(0, 1'b0, 1'b0, 1'b1, 12'h500, 12'h001, 16);
      run_conv(0, 1'b0, 1'b1, 1'b1, 12'h001, 12'h3FF, 16);
   endtask

   // Select raised before the order bit ends the frame without a result
   task t_abort();
      host.xfer(0, 3'b110, 3, rx);
      `CHK("abort push", 1'b0, valid)
      `CHK("abort idle", 2'b10, {stby, soe})
      run_conv(0, 1'b1, 1'b0, 1'b1, 12'h123, 12'h000, 16);
   endtask

   // Fill the buffer with the reader stalled, then drain it
   task automatic t_fill();
      int i;
      for (i = 0; i < 32; i++)
      begin
         @(negedge mclk_i);
         ain_a = i[11:0];
         ain_b = i[11:0];
         host.xfer(0, {1'b1, i[0], 1'b1}, 4, rx);
      end
      host.xfer(0, 3'b101, 20, rx);
      for (i = 0; i < 32; i++)
      begin
         `CHK("fill", {2'b11, i[0], i[9:0]}, {valid, data})
         pop();
      end
      `CHK("drained", 1'b0, valid)
   endtask

   initial
   begin
      rst_i = 1'b1;
      ain_a = 12'h000;
      ain_b = 12'h000;
      ready = 1'b0;
      repeat (16) @(negedge mclk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      t_single();
      t_diff();
      t_abort();
      t_fill();
      end_sim();
   end
endmodule // dual_channel_sar_adc_serial_port_tb
